// ===== fbms_pkg.sv
// package for the flash bus-mode host controller
// assumes one 40 MHz clock; all pin timings counted in pclk cycles
package fbms_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // timing figures in ns, then cycle counts derived from them
  localparam int unsigned ACC_NS = 90;
  localparam int unsigned CLR_PULSE_NS = 500;
  localparam int unsigned CLR_READ_NS = 50;
  localparam int unsigned WR_PULSE_NS = 45;
  localparam int unsigned NS_PER_CYC = 1_000_000_000 / CLK_HZ;
  localparam int unsigned ACC_CYC = (ACC_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned CLR_PULSE_CYC =
    (CLR_PULSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned CLR_READ_CYC =
    (CLR_READ_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned WR_PULSE_CYC =
    (WR_PULSE_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned CNT_W = 8;

  // APB register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;

  // control register fields
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_WR = 1;
  localparam int unsigned CTRL_CLR = 2;
  localparam int unsigned CTRL_WORD = 3;
  localparam int unsigned CTRL_BOTTOM = 4;
  localparam int unsigned CTRL_HVID = 5;

  // status register fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_IDLE_IND = 1;
  localparam int unsigned ST_SEC_LSB = 4;
  localparam int unsigned ST_RD_LSB = 16;

  // device address layout (word address A17:A0)
  localparam int unsigned DEV_AW = 18;
  localparam int unsigned SEC_HI = 17;
  localparam int unsigned SEC_LO = 12;
  localparam int unsigned ID_PIN = 9;
  localparam int unsigned ID_LOW_PIN = 6;

  typedef enum logic [2:0] {
    FBMS_IDLE = 3'b000,
    FBMS_SETUP = 3'b001,
    FBMS_STROBE = 3'b010,
    FBMS_HOLD = 3'b011,
    FBMS_CLR = 3'b100,
    FBMS_CLR_WAIT = 3'b101,
    FBMS_CLR_REC = 3'b110
  } fbms_state_type;
endpackage

// ===== fbms_host.sv
// host controller driving a parallel boot-sector flash over its pins
// assumes an APB master on pclk and the flash pins wired to a bench model
`timescale 1ns/1ps
//
// Function
// (RL1) write: strobe and select low, gate high
// (RL2) width select sets byte or word data
// (RL3) erase target named by upper sector bits
// (RL4) id reads come back on low byte
// (RL5) status reads come back on low byte
// (RL6) select and clear high give standby
// (RL7) full access time after standby exit
// (RL8) deselect during operation does not abort
// (RL9) clear pulse aborts, floats, resets device
// (RL10) clear low also means standby
// (RL11) busy held low until clearing ends
// (RL12) wait clear-to-read time before reading
// (RL13) gate high floats device data
// (RL14) top-boot sector decode of A17:A12
// (RL15) bottom-boot sector decode of A17:A12
// (RL16) byte address adds extra low bit
// (RL17) high-voltage id: A9 high, A6 low
// (RL18) protect check returns one or zero
// (RL19) id also reachable by commands
// (RL20) byte mode: DQ15 is extra address
// (RL21) address on later fall, data earlier rise
// (RL22) idle indicator high when nothing runs
module fbms_host #(
  parameter int unsigned ACC_CYCLES = fbms_pkg::ACC_CYC,
  parameter int unsigned CLR_PULSE_CYCLES = fbms_pkg::CLR_PULSE_CYC,
  parameter int unsigned CLR_READ_CYCLES = fbms_pkg::CLR_READ_CYC,
  parameter int unsigned WR_CYCLES = fbms_pkg::WR_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [17:0] fl_addr,
  output logic fl_hv_id,
  output logic [15:0] fl_dq_out,
  output logic [15:0] fl_dq_oe,
  input wire logic [15:0] fl_dq_in,
  output logic fl_chip_sel_n,
  output logic fl_write_n,
  output logic fl_out_gate_n,
  output logic fl_word_sel,
  output logic fl_clear_n,
  input wire logic idle_indicator
);
  typedef struct packed {
    fbms_pkg::fbms_state_type st;
    logic [fbms_pkg::CNT_W-1:0] cnt;
    logic wr;
    logic word;
    logic bottom;
    logic hvid;
    logic [18:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [17:0] fl_addr;
    logic fl_hv_id;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic clr_n;
    logic need_acc;
    logic [1:0] idle_sync;
    logic [31:0] dq_sync;
  } fbms_regs_type;

  fbms_regs_type r_q, r_d;
  logic [3:0] sector;
  logic [5:0] sb;

  // sector index from A17:A12 for either boot variant
  always_comb begin
    sb = r_q.addr[fbms_pkg::SEC_HI+1:fbms_pkg::SEC_LO+1];
    if (!r_q.bottom) begin
      if (sb[5:3] != 3'h7) sector = {1'b0, sb[5:3]}; // [RL14]
      else if (!sb[2]) sector = 4'h7;
      else if (sb[1]) sector = 4'hA;
      else sector = sb[0] ? 4'h9 : 4'h8;
    end else begin
      if (sb[5:3] != 3'h0) sector = 4'h3 + {1'b0, sb[5:3]}; // [RL15]
      else if (sb[2]) sector = 4'h3;
      else if (!sb[1]) sector = 4'h0;
      else sector = sb[0] ? 4'h2 : 4'h1;
    end
  end

  always_comb begin
    logic [7:0] off;
    logic apb_acc;
    off = paddr[7:0];
    r_d = r_q;
    r_d.idle_sync = {r_q.idle_sync[0], idle_indicator};
    r_d.dq_sync = {r_q.dq_sync[15:0], fl_dq_in};
    apb_acc = psel && penable && !r_q.pready;
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    if (apb_acc) begin
      r_d.pready = 1'b1;
      r_d.prdata = '0;
      // offsets 0x10 to 0xFF fall to the error default; paddr above bit 7 is not decoded
      unique case (off[7:4] == 4'h0 ? off[3:0] : 4'h1)
        fbms_pkg::REG_CTRL: begin
          if (pwrite && r_q.st == fbms_pkg::FBMS_IDLE) begin
            r_d.wr = pwdata[fbms_pkg::CTRL_WR];
            r_d.word = pwdata[fbms_pkg::CTRL_WORD]; // [RL2]
            r_d.bottom = pwdata[fbms_pkg::CTRL_BOTTOM];
            r_d.hvid = pwdata[fbms_pkg::CTRL_HVID];
            if (pwdata[fbms_pkg::CTRL_CLR]) begin
              r_d.st = fbms_pkg::FBMS_CLR;
              r_d.cnt = '0;
            end else if (pwdata[fbms_pkg::CTRL_GO]) begin
              r_d.st = fbms_pkg::FBMS_SETUP;
              r_d.cnt = '0;
            end
          end else if (pwrite) begin
            r_d.pslverr = 1'b1;
          end
          r_d.prdata = {26'h0, r_q.hvid, r_q.bottom, r_q.word, 2'h0,
                        r_q.wr};
        end
        fbms_pkg::REG_ADDR: begin
          if (pwrite) r_d.addr = pwdata[18:0];
          r_d.prdata = {13'h0, r_q.addr};
        end
        fbms_pkg::REG_WDATA: begin
          if (pwrite) r_d.wdata = pwdata[15:0];
          r_d.prdata = {16'h0, r_q.wdata};
        end
        fbms_pkg::REG_STAT: begin
          r_d.prdata = {r_q.rdata, 8'h0, sector,
                        2'h0, r_q.idle_sync[1],
                        r_q.st != fbms_pkg::FBMS_IDLE};
        end
        default: r_d.pslverr = 1'b1;
      endcase
      if (off[7:4] != 4'h0) begin
        r_d.pslverr = 1'b1;
      end
    end

    unique case (r_q.st)
      fbms_pkg::FBMS_IDLE: begin
        // standby between cycles; select and clear both high [RL6]
        r_d.ce_n = 1'b1;
        r_d.we_n = 1'b1;
        r_d.oe_n = 1'b1;
        r_d.dq_oe = '0;
      end
      fbms_pkg::FBMS_SETUP: begin
        // address settles before any strobe falls [RL21]
        if (r_q.word) r_d.fl_addr = r_q.addr[18:1]; // [RL16]
        else r_d.fl_addr = r_q.addr[18:1];
        r_d.fl_hv_id = r_q.hvid && !r_q.wr; // [RL17] [RL19]
        if (r_q.hvid && !r_q.wr) begin
          r_d.fl_addr[fbms_pkg::ID_LOW_PIN] = 1'b0; // [RL17]
        end
        r_d.ce_n = 1'b0;
        r_d.oe_n = 1'b1; // [RL1]
        // byte mode: DQ15 carries the extra low address bit
        r_d.dq_out = r_q.word ? r_q.wdata
                              : {r_q.addr[0], 7'h0, r_q.wdata[7:0]};
        r_d.dq_oe = r_q.word ? {16{r_q.wr}}
                             : {1'b1, 7'h0, {8{r_q.wr}}}; // [RL20]
        r_d.st = fbms_pkg::FBMS_STROBE;
        r_d.cnt = '0;
      end
      fbms_pkg::FBMS_STROBE: begin
        if (r_q.wr) begin
          r_d.we_n = 1'b0; // [RL1] [RL3]
        end else begin
          r_d.oe_n = 1'b0; // [RL4] [RL5]
        end
        r_d.cnt = r_q.cnt + 1'b1;
        // full select access time; leaving standby costs it again [RL7]
        if (r_q.wr ? r_q.cnt + 1 >= WR_CYCLES
                   : r_q.cnt + 1 >= ACC_CYCLES + 2) begin
          if (!r_q.wr) begin
            // only the low byte is trusted in byte or id reads
            r_d.rdata = r_q.word && !r_q.hvid ? r_q.dq_sync[31:16]
                                              : {8'h0, r_q.dq_sync[23:16]};
          end
          r_d.st = fbms_pkg::FBMS_HOLD;
        end
      end
      fbms_pkg::FBMS_HOLD: begin
        // write strobe rises first so data is taken with ce still low
        r_d.we_n = 1'b1; // [RL21]
        r_d.oe_n = 1'b1; // [RL13]
        r_d.st = fbms_pkg::FBMS_IDLE;
        r_d.fl_hv_id = 1'b0;
        // deselecting in FBMS_IDLE next leaves a running operation going [RL8]
      end
      fbms_pkg::FBMS_CLR: begin
        r_d.ce_n = 1'b1;
        r_d.oe_n = 1'b1;
        r_d.we_n = 1'b1;
        r_d.dq_oe = '0;
        r_d.clr_n = 1'b0; // [RL9] [RL10]
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt + 1 >= CLR_PULSE_CYCLES) begin
          r_d.st = fbms_pkg::FBMS_CLR_WAIT;
          r_d.cnt = '0;
        end
      end
      fbms_pkg::FBMS_CLR_WAIT: begin
        // release one cycle late so the pin stays low the full count [RL9]
        r_d.clr_n = 1'b1;
        // busy stays low until internal clearing completes [RL11] [RL22]
        if (r_q.idle_sync[1]) begin
          r_d.st = fbms_pkg::FBMS_CLR_REC;
        end
      end
      fbms_pkg::FBMS_CLR_REC: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt + 1 >= CLR_READ_CYCLES) begin // [RL12]
          r_d.st = fbms_pkg::FBMS_IDLE;
        end
      end
      default: r_d.st = fbms_pkg::FBMS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.ce_n <= 1'b1;
      r_q.we_n <= 1'b1;
      r_q.oe_n <= 1'b1;
      r_q.clr_n <= 1'b1;
      r_q.word <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign fl_addr = r_q.fl_addr;
  assign fl_hv_id = r_q.fl_hv_id;
  assign fl_dq_out = r_q.dq_out;
  assign fl_dq_oe = r_q.dq_oe;
  assign fl_chip_sel_n = r_q.ce_n;
  assign fl_write_n = r_q.we_n;
  assign fl_out_gate_n = r_q.oe_n;
  assign fl_word_sel = r_q.word;
  assign fl_clear_n = r_q.clr_n;
endmodule // fbms_host

// ===== fbms_host_chk.sv
// assertions on the flash host apb port and flash pins
// bound into fbms_host; sees its ports only
`timescale 1ns/1ps
module fbms_host_chk #(
  parameter int unsigned WR_CYCLES = 1,
  parameter int unsigned CLR_PULSE_CYCLES = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [17:0] fl_addr,
  input wire logic fl_hv_id,
  input wire logic [15:0] fl_dq_oe,
  input wire logic fl_chip_sel_n,
  input wire logic fl_write_n,
  input wire logic fl_out_gate_n,
  input wire logic fl_word_sel,
  input wire logic fl_clear_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] wr_q, clr_q;
  // low-time counters; pulses stay far below 255
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 8'h00;
      clr_q <= 8'h00;
    end else begin
      wr_q <= fl_write_n ? 8'h00 : wr_q + 8'h01;
      clr_q <= fl_clear_n ? 8'h00 : clr_q + 8'h01;
    end
  end
  sequence s_req; psel && penable && !pready; endsequence
  sequence s_ack; psel && penable && pready; endsequence
  sequence s_wlow; !fl_write_n [*2]; endsequence
  apb_ack_a: assert property (s_req |=> s_ack)
    else $error("late pready");
  wr_gate_a: assert property (
    !fl_write_n |-> !fl_chip_sel_n && fl_out_gate_n)
    else $error("write gating");
  wr_len_a: assert property (
    $rose(fl_write_n) |-> wr_q >= WR_CYCLES) else $error("short write");
  addr_hold_a: assert property (
    s_wlow |-> $stable(fl_addr)) else $error("address moved");
  gate_float_a: assert property (
    !fl_out_gate_n |-> fl_dq_oe[14:0] == 15'h0000)
    else $error("drive while gated");
  word_drv_a: assert property (
    !fl_write_n && fl_word_sel |-> fl_dq_oe == 16'hFFFF)
    else $error("word data");
  byte_drv_a: assert property (
    !fl_write_n && !fl_word_sel |-> fl_dq_oe[15:8] == 8'h80)
    else $error("byte data");
  clr_quiet_a: assert property (
    !fl_clear_n |-> fl_write_n && fl_out_gate_n) else $error("clear io");
  clr_len_a: assert property (
    $rose(fl_clear_n) |-> clr_q >= CLR_PULSE_CYCLES)
    else $error("short clear");
  hv_pin_a: assert property (
    fl_hv_id && !fl_out_gate_n |-> !fl_addr[6]) else $error("a6 high");
endmodule // fbms_host_chk

// ===== fbms_flash_model.sv
// behavioural flash on the host pins; resolves the dq wire
// pclk times access, busy, clearing, write capture and the undriven pattern
`timescale 1ns/1ps
module fbms_flash_model #(
  parameter int ACC = 2,
  parameter int BUSY = 80,
  parameter int CLR_T = 20,
  parameter logic [7:0] MAN_ID = 8'h5A, // arbitrary
  parameter logic [7:0] DEV_ID = 8'h3C, // arbitrary
  parameter logic [7:0] ST_B = 8'h6E
) (
  input wire logic pclk,
  input wire logic [17:0] fl_addr,
  input wire logic fl_hv_id,
  input wire logic [15:0] fl_dq_out,
  input wire logic [15:0] fl_dq_oe,
  input wire logic fl_chip_sel_n,
  input wire logic fl_write_n,
  input wire logic fl_out_gate_n,
  input wire logic fl_word_sel,
  input wire logic fl_clear_n,
  output logic [15:0] fl_dq_in,
  output logic idle_indicator
);
  logic [15:0] w, rd, md, lat_data;
  logic [15:0] nz = 16'h0000;
  logic [17:0] lat_addr;
  logic we_q = 1'b1;
  int busy = 0;
  int acc = 0;
  assign w = fl_addr[15:0] ^ 16'hA5C3;
  always_comb begin
    if (busy > 0) rd = {8'h00, ST_B};
    else if (fl_hv_id && !fl_addr[6])
      rd = {8'h00, fl_addr[1] ? {7'h00, fl_addr[17:15] == 3'h0} :
        fl_addr[0] ? DEV_ID : MAN_ID};
    else if (fl_word_sel) rd = w;
    else rd = {8'h00, fl_dq_out[15] ? w[15:8] : w[7:0]};
  end
  // undriven bits show a pattern flipping every cycle
  assign md = (!fl_chip_sel_n && !fl_out_gate_n && fl_clear_n &&
    acc + 1 >= ACC) ? (fl_word_sel ? 16'hFFFF : 16'h00FF) :
    16'h0000;
  assign fl_dq_in = (fl_dq_oe & fl_dq_out) |
    (~fl_dq_oe & ((md & rd) | (~md & nz)));
  assign idle_indicator = busy == 0;
  always @(posedge pclk) begin
    nz <= ~nz;
    we_q <= fl_write_n;
    acc <= (fl_chip_sel_n || !fl_clear_n) ? 0 : acc + 1;
    if (!fl_clear_n) busy <= busy > 0 ? CLR_T : 0;
    else if (!we_q && fl_write_n && !fl_chip_sel_n && fl_out_gate_n) begin
      lat_addr <= fl_addr;
      lat_data <= fl_word_sel ? fl_dq_in : {8'h00, fl_dq_in[7:0]};
      busy <= BUSY;
    end else if (busy > 0) busy <= busy - 1;
  end
endmodule // fbms_flash_model

// ===== tb_fbms_host.sv
// top testbench: apb master, flash model, bound checker
// apb inputs change by nba right after rising pclk edges
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  fail_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_fbms_host;
  localparam logic [31:0] A_C = {28'h0000000, fbms_pkg::REG_CTRL};
  localparam logic [31:0] A_A = {28'h0000000, fbms_pkg::REG_ADDR};
  localparam logic [31:0] A_W = {28'h0000000, fbms_pkg::REG_WDATA};
  localparam logic [31:0] A_S = {28'h0000000, fbms_pkg::REG_STAT};
  localparam logic [31:0] GO = 32'h00000001 << fbms_pkg::CTRL_GO;
  localparam logic [31:0] WR = 32'h00000001 << fbms_pkg::CTRL_WR;
  localparam logic [31:0] CLR = 32'h00000001 << fbms_pkg::CTRL_CLR;
  localparam logic [31:0] WD = 32'h00000001 << fbms_pkg::CTRL_WORD;
  localparam logic [31:0] BOT = 32'h00000001 << fbms_pkg::CTRL_BOTTOM;
  localparam logic [31:0] HV = 32'h00000001 << fbms_pkg::CTRL_HVID;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rdat;
  logic [17:0] fl_addr;
  logic [15:0] fl_dq_out, fl_dq_oe, fl_dq_in;
  logic pready, pslverr, err, fl_hv_id, fl_chip_sel_n, fl_write_n;
  logic fl_out_gate_n, fl_word_sel, fl_clear_n, idle_indicator;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 pclk = ~pclk;
  fbms_host #(.ACC_CYCLES(2), .CLR_PULSE_CYCLES(4), .CLR_READ_CYCLES(2),
    .WR_CYCLES(3)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fl_addr, .fl_hv_id,
    .fl_dq_out, .fl_dq_oe, .fl_dq_in, .fl_chip_sel_n, .fl_write_n,
    .fl_out_gate_n, .fl_word_sel, .fl_clear_n, .idle_indicator);
  fbms_flash_model #(.ACC(2)) u_flash (.pclk, .fl_addr, .fl_hv_id,
    .fl_dq_out, .fl_dq_oe, .fl_chip_sel_n, .fl_write_n, .fl_out_gate_n,
    .fl_word_sel, .fl_clear_n, .fl_dq_in, .idle_indicator);
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // idl also waits for the flash to report idle
  task automatic go(input logic [31:0] c, input logic idl);
    int n;
    apb(1'b1, A_C, c);
    n = 0;
    do begin
      apb(1'b0, A_S, 32'h00000000);
      n++;
    end while ((rdat[0] !== 1'b0 || (idl && rdat[1] !== 1'b1)) && n < 200);
  endtask
  task automatic t_write;
    apb(1'b1, A_A, 32'h0002468A);
    apb(1'b1, A_W, 32'h0000BEEF);
    go(GO | WR | WD, 1'b0);
    `CHK(u_flash.lat_addr, 18'h12345)
    `CHK(u_flash.lat_data, 16'hBEEF)
    go(GO | WD, 1'b0);
    `CHK(rdat[31:16], 16'h006E)
    `CHK(rdat[1], 1'b0)
    // let the program finish so the next read sees array data
    go(WD, 1'b1);
    go(GO | WD, 1'b1);
    `CHK(rdat[31:16], 16'h2345 ^ 16'hA5C3)
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, A_A, 32'h00001E1E | i);
      go(GO, 1'b1);
      `CHK(rdat[31:16], i ? 16'h00AA : 16'h00CC)
    end
    $display("write and read test done");
  endtask
  task automatic t_id;
    logic [17:0] ia [4] = '{18'h00000, 18'h00001, 18'h00002, 18'h20002};
    logic [7:0] iv [4] = '{8'h5A, 8'h3C, 8'h01, 8'h00};
    logic [10:0] st [12] = '{11'h000, 11'h306, 11'h387, 11'h3C8, 11'h3D9,
      11'h3EA, 11'h410, 11'h421, 11'h432, 11'h443, 11'h78A, 11'h607};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_A, {13'h0000, ia[i], 1'b0});
      go(GO | HV | WD, 1'b1);
      `CHK(rdat[31:16], {8'h00, iv[i]})
    end
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, A_A, {13'h0000, st[i][9:4], 12'h000, 1'b0});
      apb(1'b1, A_C, st[i][10] ? BOT : 32'h00000000);
      apb(1'b0, A_S, 32'h00000000);
      `CHK(rdat[7:4], st[i][3:0])
    end
    $display("id and sector test done");
  endtask
  task automatic t_clear;
    int c0;
    apb(1'b1, A_A, 32'h0002468A);
    apb(1'b1, A_C, GO | WR);
    apb(1'b1, A_C, GO);
    `CHK(err, 1'b1)
    apb(1'b0, 32'h00000010, 32'h00000000);
    `CHK({err, rdat}, {1'b1, 32'h00000000})
    go(32'h00000000, 1'b0);
    c0 = cyc;
    go(CLR, 1'b1);
    `CHK(rdat[1:0], 2'b10)
    `CHK(cyc - c0 < 80, 1'b1)
    go(GO | WD, 1'b1);
    `CHK(rdat[31:16], 16'h2345 ^ 16'hA5C3)
    go(CLR, 1'b1);
    `CHK(rdat[1:0], 2'b10)
    $display("clear test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_write();
    t_id();
    t_clear();
    final_report();
  end
endmodule // tb_fbms_host
bind fbms_host fbms_host_chk #(.WR_CYCLES(WR_CYCLES),
  .CLR_PULSE_CYCLES(CLR_PULSE_CYCLES)) u_chk (.pclk, .presetn, .psel,
  .penable, .pready, .fl_addr, .fl_hv_id, .fl_dq_oe, .fl_chip_sel_n,
  .fl_write_n, .fl_out_gate_n, .fl_word_sel, .fl_clear_n);
